// [core/rmf_pkg.sv]
/*
  constants, register map and carrier types of the reference monitor failure
  status block. assumes a 32-bit ahb-lite register bus, one word per register.
*/
`default_nettype none

package rmf_pkg;

  // ------------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------------
  localparam int NUM_REF = 4;
  localparam int SEL_W = 4;      // width of one loss-pin select field
  localparam int PAD_GPIO = 16;  // pin space reachable by a select field

  // ------------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------------------
  localparam logic [7:0] IDX_ISR_STAT = 8'h02;
  localparam logic [7:0] IDX_ISR_MASK = 8'h04;
  localparam logic [7:0] IDX_MON_HI = 8'h06;
  localparam logic [7:0] IDX_MON_LO = 8'h07;
  localparam logic [7:0] IDX_FMASK_HI = 8'h08;
  localparam logic [7:0] IDX_FMASK_LO = 8'h09;
  localparam logic [7:0] IDX_PREC_EN = 8'h0b;
  localparam logic [7:0] IDX_LOS_MAP = 8'h0c;
  localparam logic [7:0] IDX_FLAG_CFG = 8'h0d;

  // ------------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [3:0] RST_ISR_MASK = 4'h0;
  localparam logic [7:0] RST_FMASK = 8'h66;
  localparam logic [3:0] RST_PREC_EN = 4'hf;
  localparam logic [15:0] RST_LOS_MAP = 16'h3210;
  localparam logic [3:0] RST_FLAG_CFG = 4'h0;

  // ------------------------------------------------------------------------
  // field positions of the frequency flag pin configuration
  // ------------------------------------------------------------------------
  localparam int FLAG_REF_LSB = 0;
  localparam int FLAG_PRECISE_BIT = 2;
  localparam int FLAG_EN_BIT = 3;

  // ahb encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // four indicators of one reference, los in bit 0
  typedef struct packed {
    logic guard_expiry;
    logic freq_err;
    logic single_cycle_err;
    logic signal_loss;
  } rmf_ind_t;

  // one accepted ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } rmf_aphase_t;

endpackage : rmf_pkg

`default_nettype wire

// [core/rmf_sync.sv]
/*
  two-stage synchroniser for a bus of independent pin levels.
  assumes each bit is a slow level; no word coherence across bits.
*/
`default_nettype none

module rmf_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins in, levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : rmf_sync

`default_nettype wire

// [core/rmf_ref_ind.sv]
/*
  sticky indicator nibble of one reference, cleared by a read strobe.
  assumes set and clear come from logic on hclk.
*/
`default_nettype none

module rmf_ref_ind (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // events and read clear
  input wire rmf_pkg::rmf_ind_t set,
  input wire logic clr,
  // sticky state
  output rmf_pkg::rmf_ind_t status
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // an event in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else begin
      status <= rmf_pkg::rmf_ind_t'((status & {4{~clr}}) | set);
    end
  end

  a_set_beats_clear: assert property (clr && set.freq_err |=> status.freq_err)
    else $error("frequency event lost in clearing cycle");
  a_status_holds: assert property (!clr && status.guard_expiry |=> status.guard_expiry)
    else $error("guard indicator dropped without a read");

endmodule : rmf_ref_ind

`default_nettype wire

// [core/rmf_top.sv]
/*
  reference monitor failure status bank: sticky per-reference indicators,
  interrupt status and mask, loss-pin routing and a frequency flag pin.
  assumes monitor events come from logic on hclk and pins are asynchronous.
*/
// Register access over AHB-Lite is this design's own decision.
`default_nettype none

// How it works
// - loss status bit sets while its routed pin is high; bits 0 and 4.
// - each reference's loss pin is chosen from any general-purpose pin.
// - single-cycle failure sets its status bit; bits 1 and 5.
// - coarse or precise frequency failure sets one shared bit; bits 2 and 6.
// - guard soak timer expiry sets its status bit; bits 3 and 7.
// - no mask ever suppresses the monitor status bits.
// - even reference in bits 3..0, odd reference in bits 7..4.
// - a pin can flag only coarse or only precise frequency failure.
// - interrupt status bit sets only when its mask bit is high and failure exists.
// - failure mask nibble gates loss, single-cycle, coarse, guard into interrupt status.
module rmf_top #(
  parameter int NUM_GPIO = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // monitor events, one bit per reference
  input wire logic [3:0] single_cycle_fail,
  input wire logic [3:0] coarse_fail,
  input wire logic [3:0] precise_fail,
  input wire logic [3:0] guard_expired,
  // general-purpose pins
  input wire logic [NUM_GPIO-1:0] gpio_in,
  output logic freq_flag,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------------
  if (NUM_GPIO < 1 || NUM_GPIO > rmf_pkg::PAD_GPIO) begin : g_bad_gpio
    $error("NUM_GPIO must lie between 1 and 16");
  end

  // byte packing and the four-bit event ports serve exactly four references
  if (rmf_pkg::NUM_REF != 4) begin : g_bad_ref
    $error("NUM_REF must be 4");
  end

  // a select field must be able to name every pin of the padded pin space
  if ((2 ** rmf_pkg::SEL_W) < rmf_pkg::PAD_GPIO) begin : g_bad_sel
    $error("SEL_W too narrow for the pin space");
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------------
  rmf_pkg::rmf_aphase_t aph;
  rmf_pkg::rmf_aphase_t dph_reg;
  rmf_pkg::rmf_ind_t ind_set [rmf_pkg::NUM_REF];
  rmf_pkg::rmf_ind_t ind [rmf_pkg::NUM_REF];
  logic [3:0] isr_stat_reg;
  logic [3:0] isr_mask_reg;
  logic [7:0] fmask_hi_reg;
  logic [7:0] fmask_lo_reg;
  logic [3:0] prec_en_reg;
  logic [15:0] los_map_reg;
  logic [3:0] flag_cfg_reg;
  logic [NUM_GPIO-1:0] gpio_s;
  logic [rmf_pkg::PAD_GPIO-1:0] gpio_pad;
  logic [3:0] los_raw;
  logic [3:0] isr_cause;
  logic [3:0] isr_w1c;
  logic [7:0] rdata_next;
  logic clr_lo;
  logic clr_hi;
  logic addr_ok;
  logic wr_en;

  // ------------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------------
  // zero wait states keep the slave free of back-pressure logic
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // aligned word inside the 1 KiB window, otherwise unmapped
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);

  // address phase taken when the bus is ready and a transfer starts
  always_comb begin
    aph.valid = hsel && htrans[1] && hready && addr_ok && (hsize == rmf_pkg::HSIZE_WORD);
    aph.write = hwrite;
    aph.idx = haddr[9:2];
  end

  // data phase bookkeeping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_reg <= '0;
    end else if (hready) begin
      dph_reg <= aph;
    end
  end

  assign wr_en = dph_reg.valid && dph_reg.write;

  // read clears act on the taken address phase, same edge as hrdata loads
  assign clr_lo = aph.valid && !aph.write && (aph.idx == rmf_pkg::IDX_MON_LO);
  assign clr_hi = aph.valid && !aph.write && (aph.idx == rmf_pkg::IDX_MON_HI);

  // read multiplexer, unmapped words read zero
  always_comb begin
    if (aph.idx == rmf_pkg::IDX_ISR_STAT) begin
      rdata_next = {4'h0, isr_stat_reg};
    end else if (aph.idx == rmf_pkg::IDX_ISR_MASK) begin
      rdata_next = {4'h0, isr_mask_reg};
    end else if (aph.idx == rmf_pkg::IDX_MON_HI) begin
      rdata_next = {ind[3], ind[2]};
    end else if (aph.idx == rmf_pkg::IDX_MON_LO) begin
      rdata_next = {ind[1], ind[0]};
    end else if (aph.idx == rmf_pkg::IDX_FMASK_HI) begin
      rdata_next = fmask_hi_reg;
    end else if (aph.idx == rmf_pkg::IDX_FMASK_LO) begin
      rdata_next = fmask_lo_reg;
    end else if (aph.idx == rmf_pkg::IDX_PREC_EN) begin
      rdata_next = {4'h0, prec_en_reg};
    end else if (aph.idx == rmf_pkg::IDX_LOS_MAP) begin
      rdata_next = los_map_reg[7:0];
    end else if (aph.idx == rmf_pkg::IDX_FLAG_CFG) begin
      rdata_next = {4'h0, flag_cfg_reg};
    end else begin
      rdata_next = 8'h00;
    end
  end

  // read data registered into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (aph.valid && !aph.write) begin
      hrdata <= (aph.idx == rmf_pkg::IDX_LOS_MAP) ? {16'h0, los_map_reg} : {24'h0, rdata_next};
    end else begin
      hrdata <= 32'h0;
    end
  end

  // ------------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------------
  // writes land at the end of the data phase; monitor status is read-only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isr_mask_reg <= rmf_pkg::RST_ISR_MASK;
      fmask_hi_reg <= rmf_pkg::RST_FMASK;
      fmask_lo_reg <= rmf_pkg::RST_FMASK;
      prec_en_reg <= rmf_pkg::RST_PREC_EN;
      los_map_reg <= rmf_pkg::RST_LOS_MAP;
      flag_cfg_reg <= rmf_pkg::RST_FLAG_CFG;
    end else if (wr_en) begin
      if (dph_reg.idx == rmf_pkg::IDX_ISR_MASK) begin
        isr_mask_reg <= hwdata[3:0];
      end else if (dph_reg.idx == rmf_pkg::IDX_FMASK_HI) begin
        fmask_hi_reg <= hwdata[7:0];
      end else if (dph_reg.idx == rmf_pkg::IDX_FMASK_LO) begin
        fmask_lo_reg <= hwdata[7:0];
      end else if (dph_reg.idx == rmf_pkg::IDX_PREC_EN) begin
        prec_en_reg <= hwdata[3:0];
      end else if (dph_reg.idx == rmf_pkg::IDX_LOS_MAP) begin
        los_map_reg <= hwdata[15:0];
      end else if (dph_reg.idx == rmf_pkg::IDX_FLAG_CFG) begin
        flag_cfg_reg <= hwdata[3:0];
      end
    end
  end

  // ------------------------------------------------------------------------
  // loss pin routing
  // ------------------------------------------------------------------------
  rmf_sync #(
    .W(NUM_GPIO)
  ) u_gpio_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(gpio_in),
    .q(gpio_s)
  );

  // pins beyond NUM_GPIO read low, so a stray select never fires
  // the price: a select of NUM_GPIO or above fails silently and shows no loss
  assign gpio_pad = rmf_pkg::PAD_GPIO'(gpio_s);

  // ------------------------------------------------------------------------
  // per-reference indicators
  // ------------------------------------------------------------------------
  for (genvar i = 0; i < rmf_pkg::NUM_REF; i++) begin : g_ref
    // any pin may carry this reference's loss signal
    assign los_raw[i] = gpio_pad[los_map_reg[i*rmf_pkg::SEL_W +: rmf_pkg::SEL_W]];

    // status takes events raw, no mask is in this path
    always_comb begin
      ind_set[i].signal_loss = los_raw[i];
      ind_set[i].single_cycle_err = single_cycle_fail[i];
      ind_set[i].freq_err = coarse_fail[i] | precise_fail[i];
      ind_set[i].guard_expiry = guard_expired[i];
    end

    rmf_ref_ind u_ind (
      .hclk(hclk),
      .hresetn(hresetn),
      .set(ind_set[i]),
      .clr((i < 2) ? clr_lo : clr_hi),
      .status(ind[i])
    );
  end

  // ------------------------------------------------------------------------
  // interrupt status and line
  // ------------------------------------------------------------------------
  // the nibble gates loss, single-cycle, coarse and guard; precise has its
  // own enable so software can split the two frequency causes apart
  always_comb begin
    logic [15:0] fm;
    fm = {fmask_hi_reg, fmask_lo_reg};
    for (int r = 0; r < rmf_pkg::NUM_REF; r++) begin
      isr_cause[r] = |(fm[r*4 +: 4] & {guard_expired[r], coarse_fail[r],
                                        single_cycle_fail[r], los_raw[r]}) |
                     (prec_en_reg[r] & precise_fail[r]);
    end
  end

  assign isr_w1c = (wr_en && dph_reg.idx == rmf_pkg::IDX_ISR_STAT) ? hwdata[3:0] : 4'h0;

  // set only through the mask; a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isr_stat_reg <= 4'h0;
    end else begin
      isr_stat_reg <= (isr_stat_reg & ~isr_w1c) | (isr_cause & isr_mask_reg);
    end
  end

  // level output; clearing the mask later leaves the line up, only a write-one status clear drops it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((isr_stat_reg & ~isr_w1c) | (isr_cause & isr_mask_reg));
    end
  end

  // ------------------------------------------------------------------------
  // frequency flag pin
  // ------------------------------------------------------------------------
  // one pin shows coarse only or precise only for the chosen reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_flag <= 1'b0;
    end else begin
      freq_flag <= flag_cfg_reg[rmf_pkg::FLAG_EN_BIT] &
                   (flag_cfg_reg[rmf_pkg::FLAG_PRECISE_BIT] ?
                    precise_fail[flag_cfg_reg[rmf_pkg::FLAG_REF_LSB +: 2]] :
                    coarse_fail[flag_cfg_reg[rmf_pkg::FLAG_REF_LSB +: 2]]);
    end
  end

  // ------------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------------
  // per-reference logic is one generate body, so checks on some references
  // stand for the others; all are off while reset is low
  sequence s_read_lo;
    aph.valid && !aph.write && aph.idx == rmf_pkg::IDX_MON_LO;
  endsequence

  sequence s_quiet_lo;
    !(|single_cycle_fail[1:0]) && !(|coarse_fail[1:0]) && !(|precise_fail[1:0]) &&
    !(|guard_expired[1:0]) && !(|los_raw[1:0]);
  endsequence

  sequence s_read_hi;
    aph.valid && !aph.write && aph.idx == rmf_pkg::IDX_MON_HI;
  endsequence

  sequence s_quiet_hi;
    !(|single_cycle_fail[3:2]) && !(|coarse_fail[3:2]) && !(|precise_fail[3:2]) &&
    !(|guard_expired[3:2]) && !(|los_raw[3:2]);
  endsequence

  a_los_sets: assert property (los_raw[0] |=> ind[0].signal_loss)
    else $error("loss pin high but loss bit not set");
  a_los_route: assert property (los_map_reg[7:4] == 4'h1 && gpio_s[1] |=> ind[1].signal_loss)
    else $error("routed pin did not reach reference 1 loss bit");
  a_scm_sets: assert property (single_cycle_fail[2] |=> ind[2].single_cycle_err)
    else $error("single-cycle failure not recorded");
  a_freq_either: assert property (coarse_fail[3] || precise_fail[3] |=> ind[3].freq_err)
    else $error("frequency failure not recorded");
  a_guard_sets: assert property (guard_expired[0] |=> ind[0].guard_expiry)
    else $error("guard expiry not recorded");
  a_no_mask: assert property (fmask_lo_reg == 8'h00 && precise_fail[1] |=> ind[1].freq_err)
    else $error("mask suppressed a monitor status bit");
  a_byte_order: assert property (s_read_lo |=> hrdata[7:0] == {$past(ind[1]), $past(ind[0])})
    else $error("monitor byte order wrong");
  a_isr_needs_mask: assert property ($rose(isr_stat_reg[0]) |-> $past(isr_mask_reg[0]))
    else $error("interrupt status set while masked");
  a_nibble_gates: assert property (
    isr_mask_reg[0] && fmask_lo_reg[3] && guard_expired[0] |=> isr_stat_reg[0] && irq)
    else $error("unmasked guard failure missed interrupt");
  a_read_clears: assert property (s_read_lo ##0 s_quiet_lo |=> ind[0] == '0 && ind[1] == '0)
    else $error("read did not clear monitor status");
  a_flag_coarse: assert property (flag_cfg_reg == 4'h9 && !coarse_fail[1] |=> !freq_flag)
    else $error("flag pin shows the wrong monitor");
  a_flag_precise: assert property (
    flag_cfg_reg == 4'hd && precise_fail[1] |=> freq_flag)
    else $error("flag pin missed a precise failure");
  a_byte_order_hi: assert property (
    s_read_hi |=> hrdata[7:0] == {$past(ind[3]), $past(ind[2])})
    else $error("upper monitor byte order wrong");
  a_read_clears_hi: assert property (
    s_read_hi ##0 s_quiet_hi |=> ind[2] == '0 && ind[3] == '0)
    else $error("read did not clear upper monitor status");
  a_irq_follows: assert property (isr_stat_reg[0] && isr_w1c == 4'h0 |=> irq)
    else $error("interrupt line low while status is set");
  a_precise_gated: assert property (
    !prec_en_reg[0] && !isr_stat_reg[0] && !coarse_fail[0] && !single_cycle_fail[0] &&
    !guard_expired[0] && !los_raw[0] |=> !isr_stat_reg[0])
    else $error("disabled precise monitor reached interrupt status");

endmodule : rmf_top

`default_nettype wire

// [dv/rmf_host_bfm.sv]
/*
  host model: an ahb-lite master that issues single word transfers.
  assumes one slave whose hreadyout is fed back as hready.
*/
`default_nettype none

module rmf_host_bfm (
  // clock and bus answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------------
  // idle bus and transfer task
  // ------------------------------------------------------------------------
  // idle values from time zero so the slave never samples an unknown request
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // one single transfer; the caller enters just after a rising edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= rmf_pkg::HSIZE_WORD;
    hwdata <= ~hwdata;  // stale data never looks valid outside a data phase
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : rmf_host_bfm

`default_nettype wire

// [dv/tb.sv]
/*
  self-checking bench of the reference monitor failure status bank.
  assumes the host model drives the bus; the bench drives events and pins.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------------
  // clock, stimulus, instances
  // ------------------------------------------------------------------------
  logic hclk;
  logic hresetn;
  logic hsel, hwrite, hreadyout, hresp, freq_flag, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] ev [4];  // single-cycle, coarse, precise, guard
  logic [7:0] gpio;
  int err_count = 0;
  int check_count = 0;

  // 50 mhz bus clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  rmf_top #(.NUM_GPIO(8)) rmf_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .single_cycle_fail(ev[0]), .coarse_fail(ev[1]), .precise_fail(ev[2]),
    .guard_expired(ev[3]), .gpio_in(gpio), .freq_flag(freq_flag), .irq(irq)
  );

  rmf_host_bfm rmf_host_bfm_inst (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  // ------------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------------
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step

  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] unused;
    rmf_host_bfm_inst.xfer(1'b1, {22'h0, idx, 2'h0}, d, unused);
  endtask : wr

  // the slave answers OKAY on every transfer, so hresp is checked with each read
  task rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    rmf_host_bfm_inst.xfer(1'b0, {22'h0, idx, 2'h0}, 32'h0, d);
    chk(name, d, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : rdchk

  // one-cycle event, then one more edge so the sticky bit has landed
  task pulse(input int k, input int r);
    ev[k][r] <= 1'b1;
    step(1);
    ev[k][r] <= 1'b0;
    step(1);
  endtask : pulse

  task report_and_stop;
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------------
  task t_reset;
    rdchk("mon_lo", rmf_pkg::IDX_MON_LO, 32'h0);
    rdchk("mon_hi", rmf_pkg::IDX_MON_HI, 32'h0);
    rdchk("fmask_lo", rmf_pkg::IDX_FMASK_LO, 32'h66);
    rdchk("los_map", rmf_pkg::IDX_LOS_MAP, 32'h3210);
    wr(8'h0f, 32'hffff_ffff);
    rdchk("unmapped", 8'h0f, 32'h0);
    chk("irq_rst", {31'h0, irq}, 32'h0);
  endtask : t_reset

  // single-cycle, frequency and guard indicators of every reference, with all failure masks zeroed
  task t_events;
    int pos;
    logic [7:0] idx;
    wr(rmf_pkg::IDX_FMASK_LO, 32'h0);
    wr(rmf_pkg::IDX_FMASK_HI, 32'h0);
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 4; r++) begin
        pos = (r % 2) * 4 + (k == 0 ? 1 : (k == 3 ? 3 : 2));
        idx = (r < 2) ? rmf_pkg::IDX_MON_LO : rmf_pkg::IDX_MON_HI;
        pulse(k, r);
        step(2);
        rdchk("mon_set", idx, 32'h1 << pos);
        rdchk("mon_clr", idx, 32'h0);
      end
    end
  endtask : t_events

  // loss pins of ref0 and ref3 rerouted away from the reset mapping, ref1 and ref2 stay on pins 1 and 2
  task t_los;
    wr(rmf_pkg::IDX_LOS_MAP, 32'h5217);
    gpio <= 8'h82;
    step(4);
    gpio <= 8'h20;
    step(4);
    gpio <= 8'h00;
    step(4);
    rdchk("los_lo", rmf_pkg::IDX_MON_LO, 32'h11);
    rdchk("los_hi", rmf_pkg::IDX_MON_HI, 32'h10);
  endtask : t_los

  task t_irq;
    wr(rmf_pkg::IDX_FMASK_LO, 32'h66);
    wr(rmf_pkg::IDX_ISR_MASK, 32'h1);
    pulse(3, 0);  // guard expiry is gated off by the 0x6 nibble
    rdchk("isr_gst", rmf_pkg::IDX_ISR_STAT, 32'h0);
    wr(rmf_pkg::IDX_FMASK_LO, 32'h6e);  // guard bit of the ref0 nibble now enabled
    pulse(3, 0);
    rdchk("isr_gst_on", rmf_pkg::IDX_ISR_STAT, 32'h1);
    wr(rmf_pkg::IDX_ISR_STAT, 32'h1);
    wr(rmf_pkg::IDX_FMASK_LO, 32'h66);
    pulse(1, 1);  // ref1 interrupt mask bit is still low
    rdchk("isr_mask", rmf_pkg::IDX_ISR_STAT, 32'h0);
    pulse(1, 0);
    #1;
    chk("irq_on", {31'h0, irq}, 32'h1);
    rdchk("isr_cfm", rmf_pkg::IDX_ISR_STAT, 32'h1);
    rdchk("isr_kept", rmf_pkg::IDX_ISR_STAT, 32'h1);
    rdchk("mon_all", rmf_pkg::IDX_MON_LO, 32'h4c);
    wr(rmf_pkg::IDX_ISR_STAT, 32'h1);
    step(1);
    #1;
    chk("irq_off", {31'h0, irq}, 32'h0);
    // precise disabled for ref0: only coarse and single-cycle can now reach the interrupt status
    wr(rmf_pkg::IDX_PREC_EN, 32'he);
    pulse(2, 0);
    rdchk("isr_pfm", rmf_pkg::IDX_ISR_STAT, 32'h0);
    rdchk("mon_pfm", rmf_pkg::IDX_MON_LO, 32'h4);
    pulse(1, 0);
    rdchk("isr_cfm2", rmf_pkg::IDX_ISR_STAT, 32'h1);
    wr(rmf_pkg::IDX_ISR_STAT, 32'h1);
    wr(rmf_pkg::IDX_ISR_MASK, 32'h0);
  endtask : t_irq

  // flag pin on ref1, coarse-only then precise-only
  task t_flag;
    for (int m = 0; m < 2; m++) begin
      wr(rmf_pkg::IDX_FLAG_CFG, (m == 0) ? 32'h9 : 32'hd);
      ev[1][1] <= 1'b1;
      step(1);
      #1;
      chk("flag_cfm", {31'h0, freq_flag}, {31'h0, m == 0});
      ev[1][1] <= 1'b0;
      ev[2][1] <= 1'b1;
      step(1);
      #1;
      chk("flag_pfm", {31'h0, freq_flag}, {31'h0, m == 1});
      ev[2][1] <= 1'b0;
      step(1);
    end
  endtask : t_flag

  // ------------------------------------------------------------------------
  // main sequence and timeout
  // ------------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    gpio = 8'h00;
    ev = '{default: 4'h0};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    step(1);
    t_reset;
    t_events;
    t_los;
    t_irq;
    t_flag;
    report_and_stop;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    report_and_stop;
  end
endmodule : tb

`default_nettype wire
